// *** pkg/acdp_pkg.sv ***
/*
 * acdp_pkg: constants for the alert / charge-done pin block of a charge gauge.
 * Assumes a 100 MHz core clock and a single AHB-Lite slave port for registers.
 */
`default_nettype none
package acdp_pkg;
   // register byte offsets
   localparam logic [7:0] ACDP_OFS_STATUS = 8'h00;
   localparam logic [7:0] ACDP_OFS_CTRL = 8'h04;
   localparam logic [7:0] ACDP_OFS_ACC = 8'h08;
   localparam logic [7:0] ACDP_OFS_THR_HI = 8'h0c;
   localparam logic [7:0] ACDP_OFS_THR_LO = 8'h10;
   localparam logic [7:0] ACDP_OFS_IRQ_MASK = 8'h14;
   // control fields
   localparam int ACDP_CTRL_PRESC_LSB = 3;
   localparam int ACDP_CTRL_PIN_LSB = 1;
   localparam logic [1:0] ACDP_PIN_ALERT = 2'b10;
   localparam logic [1:0] ACDP_PIN_CHG_DONE = 2'b01;
   localparam logic [7:0] ACDP_CTRL_RST = 8'h3c;
   // status bits
   localparam int ACDP_ST_ID = 7;
   localparam int ACDP_ST_SAT = 5;
   localparam int ACDP_ST_HI = 3;
   localparam int ACDP_ST_LO = 2;
   localparam int ACDP_ST_VBAT = 1;
   localparam int ACDP_ST_LOCKOUT = 0;
   localparam logic [7:0] ACDP_ST_ALERT_MASK = 8'h7e;
   // reset values and limits
   localparam logic [15:0] ACDP_ACC_RST = 16'h7fff;
   localparam logic [15:0] ACDP_ACC_FULL = 16'hffff;
   localparam logic [15:0] ACDP_ACC_EMPTY = 16'h0000;
   localparam logic [15:0] ACDP_THR_HI_RST = 16'hffff;
   localparam logic [15:0] ACDP_THR_LO_RST = 16'h0000;
   localparam logic [2:0] ACDP_PRESC_MAX_CODE = 3'h7;
   localparam logic [7:0] ACDP_MASK_RST = 8'h00;
   // timing
   localparam int ACDP_CLK_PERIOD_NS = 10;
   localparam int ACDP_T_CHG_DONE_NS = 1000;
   localparam int ACDP_CHG_DONE_CYC = ACDP_T_CHG_DONE_NS / ACDP_CLK_PERIOD_NS;
endpackage : acdp_pkg
`default_nettype wire

// *** rtl/acdp_pin_logic.sv ***
/*
 * acdp_pin_logic: shared alert / charge-done pin, charge accumulator with
 * prescaler, thresholds, sticky status, AHB-Lite register slave.
 * Assumes integrator direction pulses are synchronous to core_clk_i and the
 * pin wire is resolved outside from the output enable.
 */
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
// Summary of operation
// R1: two control bits select pin function
// R2: pin powers up as SMBus alert
// R3: alert mode pulls pin low on threshold
// R4: charge-done high presets count to full
// R5: charger holds charge-done high one microsecond
// R6: count weight scales with prescaler over 128
// R7: any status bit except id/lockout alerts
// R8: accumulator saturates at full or empty
// R9: reset: midscale, open thresholds, alert, M=128
// R10: prescaler 1..128 overflow steps accumulator
// R11: never drive pin in charge-done mode
`default_nettype none
module acdp_pin_logic
   import acdp_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // integrator ramp reversal, one-cycle pulses
   input wire logic ramp_up_i,
   input wire logic ramp_down_i,
   // status events from analog monitors
   input wire logic vbat_low_i,
   input wire logic supply_drop_lockout_i,
   // shared pin, open drain
   input wire logic alert_or_charge_done_pin_i,
   output logic alert_or_charge_done_pin_o,
   output logic alert_or_charge_done_pin_oe_o,
   // interrupt
   output logic irq_o
);
   import acdp_pkg::*;

   logic [7:0] ctrl_q, ctrl_d;
   logic [15:0] acc_q, acc_d;
   logic [15:0] thr_hi_q, thr_hi_d;
   logic [15:0] thr_lo_q, thr_lo_d;
   logic [7:0] status_q, status_d;
   logic [7:0] mask_q, mask_d;
   logic [6:0] presc_q, presc_d;
   logic [7:0] cc_cnt_q, cc_cnt_d;
   logic pin_oe_q, pin_oe_d;
   logic irq_q, irq_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;

   logic [6:0] presc_top;
   logic step_up, step_dn, cc_preset;
   logic [7:0] ev;

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
      addr_is = (a == ofs);
   endfunction : addr_is

   // prescaler top is M-1, M a power of two from 1 to 128
   assign presc_top = 7'((8'd1 << ctrl_q[ACDP_CTRL_PRESC_LSB +: 3]) - 8'd1); // [R6] [R10]

   wire addr_ph = hsel_i & hready_i & htrans_i[1];
   wire wr_now = wr_pend_q;
   wire alert_mode = (ctrl_q[ACDP_CTRL_PIN_LSB +: 2] == ACDP_PIN_ALERT); // [R1]
   wire cc_mode = (ctrl_q[ACDP_CTRL_PIN_LSB +: 2] == ACDP_PIN_CHG_DONE); // [R1]

   // prescaler: up/down counter 0..M-1
   always_comb
   begin
      presc_d = presc_q;
      step_up = 1'b0;
      step_dn = 1'b0;
      if (ramp_up_i && !ramp_down_i)
      begin
         if (presc_q >= presc_top)
         begin
            presc_d = 7'h00;
            step_up = 1'b1; // [R10]
         end
         else
            presc_d = presc_q + 7'h01;
      end
      else if (ramp_down_i && !ramp_up_i)
      begin
         if (presc_q == 7'h00)
         begin
            presc_d = presc_top;
            step_dn = 1'b1; // [R10]
         end
         else
            presc_d = presc_q - 7'h01;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         presc_q <= 7'h00;
      end
      else
      begin
         presc_q <= presc_d;
      end
   end

   // charge-done level filter: high must persist one microsecond
   always_comb
   begin
      cc_cnt_d = 8'h00;
      cc_preset = 1'b0;
      if (cc_mode && alert_or_charge_done_pin_i)
      begin
         if (cc_cnt_q >= 8'(ACDP_CHG_DONE_CYC - 1))
         begin
            cc_cnt_d = cc_cnt_q;
            cc_preset = 1'b1; // [R4] [R5]
         end
         else
            cc_cnt_d = cc_cnt_q + 8'h01;
      end
   end

   // any low sample restarts the filter, so short glitches never preset
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cc_cnt_q <= 8'h00;
      end
      else
      begin
         cc_cnt_q <= cc_cnt_d;
      end
   end

   // accumulator, thresholds, control, mask
   always_comb
   begin
      acc_d = acc_q;
      ctrl_d = ctrl_q;
      thr_hi_d = thr_hi_q;
      thr_lo_d = thr_lo_q;
      mask_d = mask_q;
      if (step_up && acc_q != ACDP_ACC_FULL)
         acc_d = acc_q + 16'h0001; // [R8]
      else if (step_dn && acc_q != ACDP_ACC_EMPTY)
         acc_d = acc_q - 16'h0001; // [R8]
      if (wr_now)
      begin
         if (addr_is(wr_addr_q, ACDP_OFS_CTRL))
            ctrl_d = hwdata_i[7:0];
         if (addr_is(wr_addr_q, ACDP_OFS_ACC))
            acc_d = hwdata_i[15:0];
         if (addr_is(wr_addr_q, ACDP_OFS_THR_HI))
            thr_hi_d = hwdata_i[15:0];
         if (addr_is(wr_addr_q, ACDP_OFS_THR_LO))
            thr_lo_d = hwdata_i[15:0];
         if (addr_is(wr_addr_q, ACDP_OFS_IRQ_MASK))
            mask_d = hwdata_i[7:0];
      end
      if (cc_preset)
         acc_d = ACDP_ACC_FULL; // [R4]
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ctrl_q <= ACDP_CTRL_RST; // [R9] [R2]
         acc_q <= ACDP_ACC_RST; // [R9]
         thr_hi_q <= ACDP_THR_HI_RST; // [R9]
         thr_lo_q <= ACDP_THR_LO_RST; // [R9]
         mask_q <= ACDP_MASK_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         acc_q <= acc_d;
         thr_hi_q <= thr_hi_d;
         thr_lo_q <= thr_lo_d;
         mask_q <= mask_d;
      end
   end

   // sticky status: set wins over write-one-to-clear
   always_comb
   begin
      ev = 8'h00;
      ev[ACDP_ST_HI] = (acc_q > thr_hi_q);
      ev[ACDP_ST_LO] = (acc_q < thr_lo_q);
      ev[ACDP_ST_SAT] = (step_up && acc_q == ACDP_ACC_FULL)
                      | (step_dn && acc_q == ACDP_ACC_EMPTY); // [R8]
      ev[ACDP_ST_VBAT] = vbat_low_i;
      ev[ACDP_ST_LOCKOUT] = supply_drop_lockout_i;
      status_d = status_q;
      if (wr_now && addr_is(wr_addr_q, ACDP_OFS_STATUS))
         status_d = status_q & ~hwdata_i[7:0];
      status_d = status_d | ev;
      status_d[ACDP_ST_ID] = 1'b0;
      status_d[6] = 1'b0;
      status_d[4] = 1'b0;
   end

   // id and reserved bits are never stored, so they always read zero
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         status_q <= 8'h00;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   // pin and interrupt: outputs registered
   always_comb
   begin
      pin_oe_d = 1'b1;
      if (alert_mode && |(status_q & ACDP_ST_ALERT_MASK))
         pin_oe_d = 1'b0; // [R3] [R7] [R2]
      if (cc_mode)
         pin_oe_d = 1'b1; // [R11]
      irq_d = |(status_q & mask_q);
   end

   // pin released in reset, so a charger alone owns the wire then
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pin_oe_q <= 1'b1;
         irq_q <= 1'b0;
      end
      else
      begin
         pin_oe_q <= pin_oe_d;
         irq_q <= irq_d;
      end
   end

   // bus: zero wait state, write data in data phase
   always_comb
   begin
      wr_pend_d = addr_ph & hwrite_i;
      wr_addr_d = addr_ph ? haddr_i[7:0] : wr_addr_q;
      rdata_d = 32'h0000_0000;
      if (addr_ph && !hwrite_i)
      begin
         unique case (haddr_i[7:0])
            ACDP_OFS_STATUS: rdata_d = {24'h0, status_q};
            ACDP_OFS_CTRL: rdata_d = {24'h0, ctrl_q};
            ACDP_OFS_ACC: rdata_d = {16'h0, acc_q};
            ACDP_OFS_THR_HI: rdata_d = {16'h0, thr_hi_q};
            ACDP_OFS_THR_LO: rdata_d = {16'h0, thr_lo_q};
            ACDP_OFS_IRQ_MASK: rdata_d = {24'h0, mask_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // read data lasts one cycle only; idle cycles read as zero
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
      end
   end

   assign hrdata_o = rdata_q;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign alert_or_charge_done_pin_o = 1'b0;
   assign alert_or_charge_done_pin_oe_o = pin_oe_q;
   assign irq_o = irq_q;
endmodule : acdp_pin_logic
`default_nettype wire

// *** bench/acdp_checker.sv ***
/* acdp_checker: port assertions for acdp_pin_logic.
   assumes a bind from the bench top file. */
`default_nettype none
module acdp_checker
   import acdp_pkg::*;
(
   // clock, reset, bus
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // events, pin, interrupt
   input wire logic vbat_low_i,
   input wire logic alert_or_charge_done_pin_i,
   input wire logic alert_or_charge_done_pin_o,
   input wire logic alert_or_charge_done_pin_oe_o,
   input wire logic irq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ph_q, ph_d, wr_q, wr_d;
   logic [7:0] ofs_q, ofs_d, hi_q, hi_d;
   logic [1:0] mode_q, mode_d;
   wire logic oe = alert_or_charge_done_pin_oe_o;
   // pin mode shadowed from bus writes, since the checker sees ports only
   always_comb
   begin
      ph_d = hsel_i & hready_i & htrans_i[1];
      wr_d = hwrite_i;
      ofs_d = haddr_i[7:0];
      mode_d = (ph_q & wr_q & ofs_q == ACDP_OFS_CTRL) ? hwdata_i[2:1] : mode_q;
      hi_d = 8'h00;
      if (mode_q == ACDP_PIN_CHG_DONE && alert_or_charge_done_pin_i)
         hi_d = hi_q + {7'h0, hi_q != 8'hff};
   end
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
      if (sys_rst_i)
         {ph_q, wr_q, ofs_q, hi_q, mode_q} <= {18'h0, ACDP_PIN_ALERT};
      else
         {ph_q, wr_q, ofs_q, hi_q, mode_q} <= {ph_d, wr_d, ofs_d, hi_d, mode_d};
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_released;
      (mode_q != ACDP_PIN_ALERT) [*2];
   endsequence
   sequence s_acc_rd;
      ph_q && !wr_q && ofs_q == ACDP_OFS_ACC && hi_q > 8'd101;
   endsequence
   chk_reset_quiet: assert property (disable iff (1'b0)
      sys_rst_i [*2] |-> oe && !irq_o && hrdata_o == 32'h0) else $error("active in reset");
   chk_open_drain: assert property (alert_or_charge_done_pin_o == 1'b0)
      else $error("pin driven high");
   chk_pin_release: assert property (s_released |-> oe)
      else $error("pin pulled while released");
   chk_preset_full: assert property (s_acc_rd |-> hrdata_o == 32'h0000ffff)
      else $error("no preset");
   chk_vbat_alert: assert property (mode_q == ACDP_PIN_ALERT && vbat_low_i |-> ##[1:2] !oe)
      else $error("no alert");
   chk_oe_cause: assert property ($fell(oe) |-> $past(mode_q) == ACDP_PIN_ALERT)
      else $error("pull outside alert mode");
   chk_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus not okay");
   chk_rdata_gap: assert property (!ph_q |-> hrdata_o == 32'h0)
      else $error("stale read data");
endmodule : acdp_checker
`default_nettype wire

// *** bench/acdp_charger_model.sv ***
/* acdp_charger_model: charger output on the shared pin, with pull-up.
   assumes the device pulls only through its low-active enable. */
`default_nettype none
module acdp_charger_model
(
   // control
   input wire logic clk_i,
   input wire logic attach_i,
   input wire logic start_i,
   input wire logic [7:0] len_i,
   // pin
   input wire logic dev_oe_i,
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_q = 8'h00;
   // high for len_i cycles; short widths only when the bench asks
   always @(posedge clk_i)
      left_q <= start_i ? len_i : left_q - {7'h0, left_q != 8'h00};
   // detached charger leaves the wire to its pull-up
   assign pin_o = !dev_oe_i ? 1'b0 : (attach_i ? left_q != 8'h00 : 1'b1);
endmodule : acdp_charger_model
`default_nettype wire

// *** bench/alert_charge_done_pin_logic_test.sv ***
/* alert_charge_done_pin_logic_test: self-checking bench of the pin block.
   assumes the package, checker and charger model are compiled first. */
`default_nettype none
module alert_charge_done_pin_logic_test;
   timeunit 1ns;
   timeprecision 1ps;
   import acdp_pkg::*;
   logic [31:0] hrdata_o, haddr_i = 32'h0, hwdata_i = 32'h0;
   logic hreadyout_o, hresp_o, alert_or_charge_done_pin_i, alert_or_charge_done_pin_o;
   logic alert_or_charge_done_pin_oe_o, irq_o, core_clk_i = 1'b0, sys_rst_i = 1'b1;
   logic hsel_i = 1'b1, hwrite_i = 1'b0, vbat_low_i = 1'b0, supply_drop_lockout_i = 1'b0;
   logic ramp_up_i = 1'b0, ramp_down_i = 1'b0, attach = 1'b0, start = 1'b0;
   logic [1:0] htrans_i = 2'b00;
   logic [2:0] hsize_i = 3'h2;
   logic [7:0] len = 8'h0;
   int err_count = 0, comparisons = 0;
   wire logic hready_i = hreadyout_o;
   wire logic [31:0] oe32 = {31'h0, alert_or_charge_done_pin_oe_o};
   wire logic [31:0] irq32 = {31'h0, irq_o};
   always #5 core_clk_i = ~core_clk_i;
   acdp_pin_logic uut (.*);
   acdp_charger_model chg (.clk_i(core_clk_i), .attach_i(attach), .start_i(start),
      .len_i(len), .dev_oe_i(alert_or_charge_done_pin_oe_o), .pin_o(alert_or_charge_done_pin_i));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: saw %h, want %h", $time, got, exp);
      end
   endtask : check
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk_i);
      htrans_i <= 2'b10;
      haddr_i <= {24'h0, a};
      hwrite_i <= w;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
      htrans_i <= 2'b00;
      hwdata_i <= d;
      do @(posedge core_clk_i); while (hready_i !== 1'b1);
      q = hrdata_o;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
      repeat (2) @(posedge core_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      check(q, e);
   endtask : rd
   // s: 0 battery low, 1 lockout, 2 ramp up, 3 ramp down
   task automatic ev(input int s);
      @(posedge core_clk_i);
      {ramp_down_i, ramp_up_i, supply_drop_lockout_i, vbat_low_i} <= 4'h1 << s;
      @(posedge core_clk_i);
      {ramp_down_i, ramp_up_i, supply_drop_lockout_i, vbat_low_i} <= 4'h0;
      repeat (2) @(posedge core_clk_i);
   endtask : ev
   task automatic pulse(input logic [7:0] n, input int w);
      len <= n;
      start <= 1'b1;
      @(posedge core_clk_i);
      start <= 1'b0;
      repeat (w) @(posedge core_clk_i);
   endtask : pulse
   task automatic t_reset;
      rd(ACDP_OFS_CTRL, 32'h3c);
      rd(ACDP_OFS_ACC, 32'h7fff);
      rd(ACDP_OFS_THR_HI, 32'hffff);
      rd(ACDP_OFS_THR_LO, 32'h0);
      rd(8'h18, 32'h0);
      check(oe32, 32'h1);
   endtask : t_reset
   task automatic t_modes;
      wr(ACDP_OFS_IRQ_MASK, 32'h2);
      for (int m = 0; m < 4; m++)
      begin
         wr(ACDP_OFS_CTRL, {24'h0, 5'h07, m[1:0], 1'b0});
         ev(0);
         check(oe32, {31'h0, m != 2});
         check(irq32, 32'h1);
         wr(ACDP_OFS_STATUS, 32'h2);
         check(irq32, 32'h0);
      end
      wr(ACDP_OFS_CTRL, 32'h3c);
      wr(ACDP_OFS_IRQ_MASK, 32'h0);
      ev(1);
      rd(ACDP_OFS_STATUS, 32'h1);
      check(oe32 | irq32 << 1, 32'h1);
      wr(ACDP_OFS_STATUS, 32'h1);
   endtask : t_modes
   task automatic t_count;
      repeat (127) ev(2);
      rd(ACDP_OFS_ACC, 32'h7fff);
      ev(2);
      rd(ACDP_OFS_ACC, 32'h8000);
      wr(ACDP_OFS_CTRL, 32'h04);
      ev(3);
      rd(ACDP_OFS_ACC, 32'h7fff);
      wr(ACDP_OFS_ACC, 32'hffff);
      ev(2);
      rd(ACDP_OFS_ACC, 32'hffff);
      rd(ACDP_OFS_STATUS, 32'h20);
      wr(ACDP_OFS_ACC, 32'h0);
      ev(3);
      rd(ACDP_OFS_ACC, 32'h0);
      wr(ACDP_OFS_STATUS, 32'hff);
      wr(ACDP_OFS_THR_LO, 32'h1);
      rd(ACDP_OFS_STATUS, 32'h4);
      check(oe32, 32'h0);
      wr(ACDP_OFS_THR_LO, 32'h0);
      wr(ACDP_OFS_STATUS, 32'hff);
   endtask : t_count
   task automatic t_chg;
      wr(ACDP_OFS_ACC, 32'h1234);
      wr(ACDP_OFS_CTRL, 32'h3a);
      attach <= 1'b1;
      pulse(8'd99, 110);
      rd(ACDP_OFS_ACC, 32'h1234);
      pulse(8'd200, 120);
      rd(ACDP_OFS_ACC, 32'hffff);
      check(oe32, 32'h1);
      repeat (90) @(posedge core_clk_i);
      attach <= 1'b0;
      wr(ACDP_OFS_CTRL, 32'h3c);
   endtask : t_chg
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (20) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_modes;
      t_count;
      t_chg;
      print_verdict;
   end
   // the sequence needs some 1050 cycles
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      err_count++;
      print_verdict;
   end
endmodule : alert_charge_done_pin_logic_test
bind acdp_pin_logic acdp_checker chk (.*);
`default_nettype wire
